// [include/psq_pkg.sv]
// Purpose: Constants for the port status and queue register block
// Assumes: Avalon-MM byte addressing, 32-bit data, 8-bit registers
// Notes: Offsets are byte addresses of aligned words
package psq_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_OPCTL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_XCTL = 4'h8;
  // Operation control fields
  localparam int OPCTL_SPLIT_LO = 0;
  localparam int OPCTL_TAIL_BIT = 2;
  localparam int OPCTL_MAC_LB_R = 6;
  localparam int OPCTL_MAC_LB_L = 7;
  localparam logic [7:0] OPCTL_RST = 8'h00;
  localparam logic [7:0] OPCTL_WMASK = 8'hc7;
  // Media-independent control fields
  localparam int XCTL_RXFC_BIT = 3;
  localparam int XCTL_SPD_LSB = 4;
  localparam int XCTL_TXFC_BIT = 5;
  localparam int XCTL_DUP_BIT = 6;
  localparam int XCTL_SPD_MSB = 7;
  localparam logic [7:0] XCTL_RST = 8'h40;
  // Status fields
  localparam int STAT_RXFC = 0;
  localparam int STAT_TXFC = 1;
  localparam int STAT_DUP = 2;
  localparam int STAT_SPD_LO = 3;
  // Queue split encodings
  localparam logic [1:0] SPLIT_ONE = 2'h0;
  localparam logic [1:0] SPLIT_TWO = 2'h1;
  localparam logic [1:0] SPLIT_FOUR = 2'h2;
  localparam logic [1:0] SPLIT_RSVD = 2'h3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// [logic/psq_port_regs.sv]
// Purpose: Per-port operation control and port status registers
// Assumes: Single sys_clk domain; PHY link inputs are from other domains
// Notes: One wait state on every access while clk_en is high; a request stays pending while clk_en is low
//
// Summary of operation
// RULE_01: Two-bit queue split field, read/write, resets to zero; three reserved.
// RULE_02: Split value 10 selects four priority-based egress queues.
// RULE_03: Split value 01 selects two priority-based egress queues.
// RULE_04: Split value 00 selects one queue, priority ignored.
// RULE_05: Tail tag bit zero disables tail tag insert and removal.
// RULE_06: Tail tag bit set marks host port; software sets only one port.
// RULE_07: Media-independent port speed status mirrors configured speed bits.
// RULE_08: PHY port speed status reports negotiated link speed.
// RULE_09: Media-independent duplex status mirrors duplex control bit.
// RULE_10: PHY port duplex status reports negotiated duplex.
// RULE_11: Media-independent transmit flow status mirrors its control bit.
// RULE_12: Media-independent receive flow status mirrors its control bit.
// RULE_13: PHY flow status set only when advertised, link up, agreed.
// RULE_14: PHY register range exists only on ports with a PHY.
// RULE_15: Status reads have no side effect, writes ignored, top bits zero.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module psq_port_regs #(
  parameter bit HAS_PHY = 1'b0
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [psq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // PHY link state, asynchronous
  input wire logic [1:0] phy_speed,
  input wire logic phy_duplex,
  input wire logic phy_link_up,
  input wire logic [1:0] phy_pause_adv,
  input wire logic phy_tx_pause_agreed,
  input wire logic phy_rx_pause_agreed,
  // Block controls
  output logic [1:0] egress_queue_count_log2,
  output logic egress_priority_en,
  output logic tail_tag_en,
  output logic host_port,
  output logic mac_loopback_local,
  output logic mac_loopback_remote,
  output logic phy_range_present
);

  logic [7:0] port_operation_control;
  logic [7:0] next_port_operation_control;
  logic [7:0] media_independent_port;
  logic [7:0] next_media_independent_port;
  logic [7:0] port_link_state;
  logic [7:0] next_port_link_state;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [7:0] phy_s1;
  logic [7:0] phy_s2;
  logic [7:0] phy_in;
  logic [1:0] spd_cfg;
  logic [1:0] split;
  logic [7:0] wdata;
  logic req;

  // Two-flop synchroniser for the PHY link pins
  assign phy_in = {phy_speed, phy_duplex, phy_link_up, phy_pause_adv,
                   phy_tx_pause_agreed, phy_rx_pause_agreed};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phy_s1 <= 8'h00;
      phy_s2 <= 8'h00;
    end else if (clk_en) begin
      phy_s1 <= phy_in;
      phy_s2 <= phy_s1;
    end
  end

  assign req = (avs_read || avs_write) && !ack;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wdata = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

  // Register writes and status computation
  always_comb begin
    next_port_operation_control = port_operation_control;
    next_media_independent_port = media_independent_port;
    next_ack = req && clk_en;
    if (req && avs_write && avs_byteenable[0]) begin
      if (avs_address == psq_pkg::OFS_OPCTL) begin
        // Reserved bits stay zero
        next_port_operation_control = wdata & psq_pkg::OPCTL_WMASK; // RULE_01
      end else if (avs_address == psq_pkg::OFS_XCTL) begin
        next_media_independent_port = wdata;
      end
      // Status offset falls through: write ignored
    end
    spd_cfg = {media_independent_port[psq_pkg::XCTL_SPD_MSB],
               media_independent_port[psq_pkg::XCTL_SPD_LSB]};
    next_port_link_state = 8'h00; // RULE_15
    if (HAS_PHY) begin
      next_port_link_state[psq_pkg::STAT_SPD_LO +: 2] = phy_s2[7:6]; // RULE_08
      next_port_link_state[psq_pkg::STAT_DUP] = phy_s2[5]; // RULE_10
      // Flow control needs advertisement, link and agreement
      next_port_link_state[psq_pkg::STAT_TXFC] =
        (|phy_s2[3:2]) && phy_s2[4] && phy_s2[1]; // RULE_13
      next_port_link_state[psq_pkg::STAT_RXFC] =
        (|phy_s2[3:2]) && phy_s2[4] && phy_s2[0]; // RULE_13
    end else begin
      next_port_link_state[psq_pkg::STAT_SPD_LO +: 2] = spd_cfg; // RULE_07
      next_port_link_state[psq_pkg::STAT_DUP] =
        media_independent_port[psq_pkg::XCTL_DUP_BIT]; // RULE_09
      next_port_link_state[psq_pkg::STAT_TXFC] =
        media_independent_port[psq_pkg::XCTL_TXFC_BIT]; // RULE_11
      next_port_link_state[psq_pkg::STAT_RXFC] =
        media_independent_port[psq_pkg::XCTL_RXFC_BIT]; // RULE_12
    end
    next_readdata = psq_pkg::UNMAPPED_DATA;
    if (avs_address == psq_pkg::OFS_OPCTL) begin
      next_readdata = {24'h000000, port_operation_control};
    end else if (avs_address == psq_pkg::OFS_STATUS) begin
      next_readdata = {24'h000000, port_link_state}; // RULE_15
    end else if (avs_address == psq_pkg::OFS_XCTL) begin
      next_readdata = {24'h000000, media_independent_port};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_operation_control <= psq_pkg::OPCTL_RST;
      media_independent_port <= psq_pkg::XCTL_RST;
      port_link_state <= 8'h00;
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      port_operation_control <= next_port_operation_control;
      media_independent_port <= next_media_independent_port;
      port_link_state <= next_port_link_state;
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // Queue split decode; reserved value falls back to one queue
  assign split = port_operation_control[psq_pkg::OPCTL_SPLIT_LO +: 2];
  always_comb begin
    case (split)
      psq_pkg::SPLIT_FOUR: egress_queue_count_log2 = 2'h2; // RULE_02
      psq_pkg::SPLIT_TWO: egress_queue_count_log2 = 2'h1; // RULE_03
      default: egress_queue_count_log2 = 2'h0; // RULE_04
    endcase
  end
  assign egress_priority_en = (split == psq_pkg::SPLIT_FOUR) ||
                              (split == psq_pkg::SPLIT_TWO); // RULE_04
  assign tail_tag_en = port_operation_control[psq_pkg::OPCTL_TAIL_BIT]; // RULE_05
  // Uniqueness across ports is software's duty
  assign host_port = port_operation_control[psq_pkg::OPCTL_TAIL_BIT]; // RULE_06
  assign mac_loopback_local = port_operation_control[psq_pkg::OPCTL_MAC_LB_L];
  assign mac_loopback_remote = port_operation_control[psq_pkg::OPCTL_MAC_LB_R];
  assign phy_range_present = HAS_PHY; // RULE_14

endmodule // psq_port_regs

// [tb/psq_port_regs_sva.sv]
// Purpose: Checks for the port register block
// Assumes: One clock, async active-low reset
// Notes: Sees only top-level ports
`timescale 1ns/1ps
module psq_chk #(
  parameter bit HAS_PHY = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [psq_pkg::ADDR_W-1:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Controls
  input wire logic [1:0] egress_queue_count_log2,
  input wire logic egress_priority_en,
  input wire logic tail_tag_en,
  input wire logic host_port,
  input wire logic phy_range_present
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  split_legal_a: assert property (egress_queue_count_log2 != 2'h3)
    else $error("queue count out of range");
  split_hold_a: assert property (!avs_write |=> $stable(egress_queue_count_log2))
    else $error("queue count moved without write");
  prio_map_a: assert property
    (egress_priority_en == (egress_queue_count_log2 != 2'h0))
    else $error("priority enable wrong");
  tag_hold_a: assert property (!avs_write |=> $stable(tail_tag_en))
    else $error("tail tag moved without write");
  host_tag_a: assert property (host_port == tail_tag_en)
    else $error("host port differs from tail tag");
  phy_range_a: assert property (phy_range_present == HAS_PHY)
    else $error("phy range flag wrong");
  rd_upper_a: assert property
    (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  stat_rsvd_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == psq_pkg::OFS_STATUS |-> avs_readdata[7:5] == 3'h0)
    else $error("status reserved bits set");
endmodule // psq_chk
bind psq_port_regs psq_chk #(.HAS_PHY(HAS_PHY)) chk (.*);

// [tb/testbench.sv]
// Purpose: Self-checking bench for the port register block
// Assumes: Media-independent port, one wait state
// Notes: Random mirror values; speed 11 avoided
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [psq_pkg::ADDR_W-1:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0] phy_speed = 2'h0, phy_pause_adv = 2'h0, egress_queue_count_log2;
  logic phy_duplex = 1'b0, phy_link_up = 1'b0;
  logic phy_tx_pause_agreed = 1'b0, phy_rx_pause_agreed = 1'b0;
  logic egress_priority_en, tail_tag_en, host_port, phy_range_present;
  logic mac_loopback_local, mac_loopback_remote;
  logic [7:0] x;
  int n_mismatch = 0, comparisons = 0, seed = 93795;
  always #10 sys_clk = ~sys_clk;
  psq_port_regs dut (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Edge passes first so a release and a new request never share a step
  task acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge sys_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function logic [31:0] stat(input logic [7:0] c);
    return {27'h0, c[7], c[4], c[6], c[5], c[3]};
  endfunction
  task conclude;
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    conclude;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    acc(1'b0, psq_pkg::OFS_OPCTL, 32'h0, 4'hf);
    chk(rd, 32'h0);
    acc(1'b0, psq_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h4);
    for (int v = 0; v < 4; v++) begin
      acc(1'b1, psq_pkg::OFS_OPCTL, 32'(v | ((v & 1) << 2)), 4'hf);
      @(posedge sys_clk);
      chk(32'(egress_queue_count_log2), 32'(v == 3 ? 0 : v));
      chk(32'(tail_tag_en), 32'(v & 1));
      chk(32'(host_port), 32'(v & 1));
      chk(32'(egress_priority_en), 32'(v == 1 || v == 2));
    end
    acc(1'b1, psq_pkg::OFS_OPCTL, 32'hc0, 4'hf);
    @(posedge sys_clk);
    chk({30'h0, mac_loopback_local, mac_loopback_remote}, 32'h3);
    // Frozen clock enable must hold the request pending
    clk_en <= 1'b0;
    avs_address <= psq_pkg::OFS_OPCTL;
    avs_writedata <= 32'h1;
    avs_write <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(avs_waitrequest), 32'h1);
    chk(32'(egress_queue_count_log2), 32'h0);
    clk_en <= 1'b1;
    @(posedge sys_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge sys_clk);
    chk(32'(egress_queue_count_log2), 32'h1);
    acc(1'b1, psq_pkg::OFS_OPCTL, 32'h7, 4'hf);
    acc(1'b1, psq_pkg::OFS_OPCTL, 32'h0, 4'h0);
    acc(1'b0, psq_pkg::OFS_OPCTL, 32'h0, 4'hf);
    chk(rd, 32'h7);
    for (int i = 0; i < 20; i++) begin
      x = (i == 0) ? 8'ha8 : (i == 1) ? 8'h50 : 8'($random(seed));
      if (x[7]) x[4] = 1'b0;
      {phy_speed, phy_duplex, phy_link_up, phy_pause_adv} <= 6'($random(seed));
      acc(1'b1, psq_pkg::OFS_XCTL, {24'h0, x}, 4'hf);
      acc(1'b1, psq_pkg::OFS_STATUS, 32'hff, 4'hf);
      acc(1'b0, psq_pkg::OFS_STATUS, 32'h0, 4'hf);
      chk(rd, stat(x));
    end
    acc(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rd, 32'h0);
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    acc(1'b0, psq_pkg::OFS_OPCTL, 32'h0, 4'hf);
    chk(rd, 32'h0);
    conclude;
  end
endmodule // testbench
